// ==== rtl/coproc_defs.svh ====
// Widths and timing counts of the memory, branch and loop-counter unit.
`ifndef COPROC_DEFS_SVH
`define COPROC_DEFS_SVH

`define PC_W          11
`define GPR_W         16
`define OFFSET_W      10
`define IMM_ADDR_W    13
`define STEP_W        8
`define CNT_W         8
`define TAG_PAD_W     5
`define EXEC_MEM_CYC  3'd4
`define EXEC_SHORT    3'd2
`define FETCH_LONG    3'd4
`define FETCH_SHORT   3'd2

`endif

// ==== rtl/coproc_pkg.sv ====
// Types shared by the memory, branch and loop-counter unit.
`include "coproc_defs.svh"

package coproc_pkg;

    typedef enum logic [3:0] {
        op_none               = 4'h0,
        mem_write_op          = 4'h1,
        mem_read_op           = 4'h2,
        branch_abs_op         = 4'h3,
        branch_rel_on_accum   = 4'h4,
        branch_rel_on_counter = 4'h5,
        counter_clear_op      = 4'h6,
        counter_add_op        = 4'h7,
        counter_sub           = 4'h8
    } op_e;

    typedef enum logic [2:0] {
        cond_always        = 3'h0,
        cond_zero          = 3'h1,
        cond_carry_out     = 3'h2,
        cond_min_met       = 3'h3,
        cond_below         = 3'h4,
        cond_below_or_same = 3'h5
    } cond_e;

    typedef enum logic [1:0] {
        st_idle  = 2'b00,
        st_exec  = 2'b01,
        st_fetch = 2'b10
    } state_e;

    typedef struct packed {
        op_e                      op;
        cond_e                    cond;
        logic [1:0]               val_sel;
        logic [1:0]               base_sel;
        logic                     use_reg_target;
        logic [`OFFSET_W-1:0]     offset;
        logic [`IMM_ADDR_W-1:0]   imm_addr;
        logic [`STEP_W-1:0]       step;
        logic [`GPR_W-1:0]        threshold;
        logic [7:0]               value;
    } instr_s;

    typedef struct packed {
        logic [3:0][`GPR_W-1:0]   val;
    } gpr_s;

    typedef struct packed {
        logic                     we;
        logic [`PC_W-1:0]         addr;
        logic [31:0]              wdata;
    } mem_cmd_s;

    typedef struct packed {
        logic                     valid;
        logic [1:0]               sel;
        logic [`GPR_W-1:0]        data;
    } wb_s;

    typedef struct packed {
        logic                     load;
        logic [`PC_W-1:0]         target;
    } branch_s;

    typedef struct packed {
        state_e                   state;
        logic [2:0]               cnt;
        instr_s                   instr;
        logic                     granted;
        logic                     taken;
        logic [`PC_W-1:0]         target;
        logic [`GPR_W-1:0]        rdata;
        logic                     zero_flag;
        logic                     ovf_flag;
        logic [`CNT_W-1:0]        counter;
        mem_cmd_s                 mem;
        wb_s                      wb;
        branch_s                  br;
        logic                     done;
    } unit_s;

endpackage

// ==== rtl/mem_word_pack.sv ====
// Effective word address and tagged store word of a memory access.
`timescale 1ns/1ps
`include "coproc_defs.svh"
module mem_word_pack
    import coproc_pkg::*;
(
    input  wire logic [`GPR_W-1:0]    base,
    input  wire logic [`OFFSET_W-1:0] offset,
    input  wire logic [`PC_W-1:0]     pc,
    input  wire logic [`GPR_W-1:0]    value,
    output logic      [`PC_W-1:0]     addr,
    output logic      [31:0]          word
);

    logic signed [`OFFSET_W-1:0] word_step;

    // The byte offset becomes a word step by an arithmetic shift.
    assign word_step = $signed(offset) >>> 2;
    assign addr = base[`PC_W-1:0]
                + `PC_W'($signed(word_step));
    assign word = {pc, {`TAG_PAD_W{1'b0}}, value};

endmodule // mem_word_pack

// ==== rtl/branch_cond_eval.sv ====
// Branch condition evaluation for absolute and relative branches.
`timescale 1ns/1ps
`include "coproc_defs.svh"
module branch_cond_eval
    import coproc_pkg::*;
(
    input  wire op_e                 op,
    input  wire cond_e               cond,
    input  wire logic [`GPR_W-1:0]   accum,
    input  wire logic [`CNT_W-1:0]   counter,
    input  wire logic [`GPR_W-1:0]   threshold,
    input  wire logic                zero_flag,
    input  wire logic                ovf_flag,
    output logic                     taken
);

    logic [`CNT_W-1:0] cnt_thr;

    assign cnt_thr = threshold[`CNT_W-1:0];

    always_comb begin
        taken = 1'b0;
        case (op)
            branch_abs_op: begin
                case (cond)
                    cond_zero:      taken = zero_flag;
                    cond_carry_out: taken = ovf_flag;
                    default:        taken = 1'b1;
                endcase
            end
            branch_rel_on_accum: begin
                taken = (cond == cond_below) ? (accum < threshold)
                                             : (accum >= threshold);
            end
            branch_rel_on_counter: begin
                case (cond)
                    cond_below:         taken = counter < cnt_thr;
                    cond_below_or_same: taken = counter <= cnt_thr;
                    default:            taken = counter >= cnt_thr;
                endcase
            end
            default: taken = 1'b0;
        endcase
    end

endmodule // branch_cond_eval

// ==== rtl/coproc_mem_branch_stage_unit.sv ====
// Memory, branch and loop-counter execution unit of the coprocessor.
// Functional notes
// - Store puts source value in low half-word.
// - Store upper half holds pc then five zeros.
// - Word address is base plus byte offset/4.
// - Load copies low half-word into destination.
// - Memory ops: four execute, four fetch cycles.
// - Absolute target: register word or aligned immediate.
// - Absolute branch: always, on zero, on overflow.
// - Branches: two execute, two fetch cycles.
// - Relative target is position plus byte step/4.
// - Accumulator branch: min-met or below threshold.
// - Counter branch: below, below-or-same, min-met.
// - Counter clear sets loop counter to zero.
// - Counter add adds eight-bit immediate.
// - Counter ops: two execute, four fetch cycles.
// - Counter subtract removes eight-bit immediate.
// - Fetch is two after branch, else four.
// - Memory access stalls until main CPUs yield.
`timescale 1ns/1ps
`include "coproc_defs.svh"
module coproc_mem_branch_stage_unit
    import coproc_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                issue_valid,
    output logic                     issue_ready,
    input  wire instr_s              issue_instr,
    input  wire logic [`PC_W-1:0]    issue_pc,
    input  wire gpr_s                gpr,
    input  wire logic                alu_flags_valid,
    input  wire logic                alu_zero,
    input  wire logic                alu_ovf,
    output logic                     mem_req,
    output mem_cmd_s                 mem_cmd,
    input  wire logic                mem_gnt,
    input  wire logic [31:0]         mem_rdata,
    output wb_s                      wb,
    output branch_s                  branch,
    output logic                     done,
    output logic [`CNT_W-1:0]        loop_count,
    output logic                     zero_flag,
    output logic                     ovf_flag
);

    unit_s s_reg;
    unit_s s_next;

    logic [`GPR_W-1:0]    val_word;
    logic [`GPR_W-1:0]    base_word;
    logic [`PC_W-1:0]     eff_addr;
    logic [31:0]          store_word;
    logic                 cond_taken;
    logic [`PC_W-1:0]     abs_target;
    logic [`PC_W-1:0]     rel_target;
    logic signed [`STEP_W-1:0] step_words;
    logic                 is_mem;
    logic                 exec_end;
    logic                 grant_now;

    assign val_word  = gpr.val[issue_instr.val_sel];
    assign base_word = gpr.val[issue_instr.base_sel];

    mem_word_pack u_pack (
        .base   (base_word),
        .offset (issue_instr.offset),
        .pc     (issue_pc),
        .value  (val_word),
        .addr   (eff_addr),
        .word   (store_word)
    );

    branch_cond_eval u_cond (
        .op        (issue_instr.op),
        .cond      (issue_instr.cond),
        .accum     (gpr.val[0]),
        .counter   (s_reg.counter),
        .threshold (issue_instr.threshold),
        .zero_flag (s_reg.zero_flag),
        .ovf_flag  (s_reg.ovf_flag),
        .taken     (cond_taken)
    );

    // Register targets are word addresses; the immediate is in bytes.
    assign abs_target = issue_instr.use_reg_target
                      ? base_word[`PC_W-1:0]
                      : issue_instr.imm_addr[`IMM_ADDR_W-1:2];
    assign step_words = $signed(issue_instr.step) >>> 2;
    assign rel_target = issue_pc + `PC_W'($signed(step_words));

    assign is_mem = (s_reg.instr.op == mem_write_op)
                 || (s_reg.instr.op == mem_read_op);
    // The main CPUs win the memory; the request waits for the grant.
    assign mem_req   = (s_reg.state == st_exec) && is_mem
                    && !s_reg.granted;
    assign grant_now = mem_req && mem_gnt;
    assign exec_end  = (s_reg.state == st_exec) && (s_reg.cnt == 3'd0)
                    && (!is_mem || s_reg.granted || grant_now);

    always_comb begin
        s_next = s_reg;
        s_next.wb.valid = 1'b0;
        s_next.br.load  = 1'b0;
        s_next.done     = 1'b0;

        // Flags follow ALU results only and are held otherwise.
        if (alu_flags_valid) begin
            s_next.zero_flag = alu_zero;
            s_next.ovf_flag  = alu_ovf;
        end

        case (s_reg.state)
            st_idle: begin
                if (issue_valid && issue_instr.op != op_none) begin
                    s_next.state   = st_exec;
                    s_next.instr   = issue_instr;
                    s_next.granted = 1'b0;
                    s_next.taken   = cond_taken;
                    s_next.target  = rel_target;
                    if (issue_instr.op == branch_abs_op) begin
                        s_next.target = abs_target;
                    end
                    if (issue_instr.op == mem_write_op
                        || issue_instr.op == mem_read_op) begin
                        s_next.cnt = `EXEC_MEM_CYC - 3'd1;
                    end else begin
                        s_next.cnt = `EXEC_SHORT - 3'd1;
                    end
                    s_next.mem.we    = (issue_instr.op == mem_write_op);
                    s_next.mem.addr  = eff_addr;
                    s_next.mem.wdata = store_word;
                end
            end
            st_exec: begin
                if (grant_now) begin
                    s_next.granted = 1'b1;
                    s_next.rdata   = mem_rdata[`GPR_W-1:0];
                end
                if (s_reg.cnt != 3'd0) begin
                    s_next.cnt = s_reg.cnt - 3'd1;
                end
                if (exec_end) begin
                    s_next.state = st_fetch;
                    case (s_reg.instr.op)
                        mem_read_op: begin
                            s_next.wb.valid = 1'b1;
                            s_next.wb.sel   = s_reg.instr.val_sel;
                            s_next.wb.data  = grant_now
                                ? mem_rdata[`GPR_W-1:0]
                                : s_reg.rdata;
                        end
                        counter_clear_op: begin
                            s_next.counter = '0;
                        end
                        counter_add_op: begin
                            s_next.counter = s_reg.counter
                                + s_reg.instr.value;
                        end
                        counter_sub: begin
                            s_next.counter = s_reg.counter
                                - s_reg.instr.value;
                        end
                        default: begin
                        end
                    endcase
                    if (s_reg.instr.op == branch_abs_op
                        || s_reg.instr.op == branch_rel_on_accum
                        || s_reg.instr.op == branch_rel_on_counter) begin
                        s_next.br.load   = s_reg.taken;
                        s_next.br.target = s_reg.target;
                        s_next.cnt = `FETCH_SHORT - 3'd1;
                    end else begin
                        s_next.cnt = `FETCH_LONG - 3'd1;
                    end
                end
            end
            st_fetch: begin
                if (s_reg.cnt == 3'd0) begin
                    s_next.state = st_idle;
                    s_next.done  = 1'b1;
                end else begin
                    s_next.cnt = s_reg.cnt - 3'd1;
                end
            end
            default: begin
                s_next.state = st_idle;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign issue_ready = (s_reg.state == st_idle);
    assign mem_cmd     = s_reg.mem;
    assign wb          = s_reg.wb;
    assign branch      = s_reg.br;
    assign done        = s_reg.done;
    assign loop_count  = s_reg.counter;
    assign zero_flag   = s_reg.zero_flag;
    assign ovf_flag    = s_reg.ovf_flag;

endmodule // coproc_mem_branch_stage_unit

// ==== dv/unit_chk.sv ====
// Port assertions for the memory, branch and counter unit.
`timescale 1ns/1ps
module unit_chk
    import coproc_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        issue_ready,
    input wire logic        alu_flags_valid,
    input wire logic        alu_zero,
    input wire logic        alu_ovf,
    input wire logic        mem_req,
    input wire mem_cmd_s    mem_cmd,
    input wire logic        mem_gnt,
    input wire wb_s         wb,
    input wire branch_s     branch,
    input wire logic        done,
    input wire logic        zero_flag,
    input wire logic        ovf_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_flags_hold: assert property (
        !alu_flags_valid |=> $stable({zero_flag, ovf_flag}))
        else $error("flags moved without an alu result");
    chk_flags_load: assert property (
        alu_flags_valid |=> zero_flag == $past(alu_zero) &&
        ovf_flag == $past(alu_ovf)) else $error("flags not loaded");
    chk_req_stall: assert property (
        mem_req && !mem_gnt |=> mem_req && $stable(mem_cmd))
        else $error("request dropped or changed while stalled");
    chk_store_pad: assert property (
        mem_req && mem_cmd.we |-> mem_cmd.wdata[20:16] == 5'h00)
        else $error("store tag padding not zero");
    chk_read_wb: assert property (
        mem_req && mem_gnt && !mem_cmd.we |-> ##[1:4] wb.valid)
        else $error("no write-back after read grant");
    chk_wb_read: assert property (
        wb.valid |-> !mem_cmd.we) else $error("write-back after store");
    chk_mem_time: assert property (
        mem_req && mem_gnt |-> ##[5:8] done)
        else $error("memory op end out of time");
    chk_branch_time: assert property (
        branch.load |-> ##[1:3] done) else $error("branch end late");
    chk_idle_quiet: assert property (
        issue_ready |-> !mem_req) else $error("request while idle");
    cover property (mem_req && !mem_gnt);
    cover property (branch.load);
    cover property (wb.valid);
endmodule // unit_chk

bind coproc_mem_branch_stage_unit unit_chk chk_u (.clk, .rst, .issue_ready,
    .alu_flags_valid, .alu_zero, .alu_ovf, .mem_req, .mem_cmd, .mem_gnt,
    .wb, .branch, .done, .zero_flag, .ovf_flag);

// ==== dv/shared_mem_model.sv ====
// Shared memory whose grant is held back while main CPUs use it.
`timescale 1ns/1ps
module shared_mem_model
    import coproc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       mem_req,
    input  wire mem_cmd_s   mem_cmd,
    input  wire logic [3:0] stall,
    output logic            mem_gnt,
    output logic [31:0]     mem_rdata
);
    logic [31:0] mem [0:2047];
    logic [3:0]  wait_reg;
    logic [31:0] last_reg;
    assign mem_gnt = mem_req && (wait_reg >= stall);
    // Outside a grant the data lines show no stale word.
    assign mem_rdata = mem_gnt ? mem[mem_cmd.addr] : ~last_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_reg <= 4'h0;
            last_reg <= 32'h0;
        end else begin
            wait_reg <= (mem_req && !mem_gnt) ? wait_reg + 4'h1 : 4'h0;
            if (mem_gnt) begin
                last_reg <= mem_rdata;
                if (mem_cmd.we) mem[mem_cmd.addr] <= mem_cmd.wdata;
            end
        end
    end
endmodule // shared_mem_model

// ==== dv/coproc_mem_branch_stage_unit_tb.sv ====
// Self-checking bench of the memory, branch and counter unit.
`timescale 1ns/1ps
module coproc_mem_branch_stage_unit_tb
    import coproc_pkg::*;
;
    logic        clk, rst, issue_valid, issue_ready, done;
    logic        alu_flags_valid, alu_zero, alu_ovf;
    logic        mem_req, mem_gnt, zero_flag, ovf_flag;
    logic [3:0]  stall;
    logic [10:0] issue_pc;
    logic [31:0] mem_rdata;
    logic [7:0]  loop_count;
    instr_s      issue_instr, i;
    gpr_s        gpr;
    mem_cmd_s    mem_cmd, got_cmd;
    wb_s         wb, got_wb;
    branch_s     branch, got_br;
    int          err_total, n_compared, lat, lat_br, lat_st;

    coproc_mem_branch_stage_unit dut_u (.clk, .rst, .issue_valid,
        .issue_ready, .issue_instr, .issue_pc, .gpr, .alu_flags_valid,
        .alu_zero, .alu_ovf, .mem_req, .mem_cmd, .mem_gnt, .mem_rdata,
        .wb, .branch, .done, .loop_count, .zero_flag, .ovf_flag);
    shared_mem_model mem_u (.clk, .rst, .mem_req, .mem_cmd, .stall,
        .mem_gnt, .mem_rdata);

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #50000;
        err_total++;
        results;
    end

    task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task results;
        if (err_total == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task mk(op_e o, cond_e c, logic [15:0] t, logic [7:0] b);
        i = '0;
        i.op = o;
        i.cond = c;
        i.threshold = t;
        i.step = b;
        i.value = b;
    endtask
    // Issues i and counts cycles from the taking edge until done.
    task go(logic [10:0] pc);
        got_wb = '0;
        got_br = '0;
        got_cmd = '0;
        lat = -1;
        @(posedge clk);
        issue_instr <= i;
        issue_pc <= pc;
        issue_valid <= 1'b1;
        @(posedge clk);
        issue_valid <= 1'b0;
        do begin
            @(negedge clk);
            lat++;
            if (wb.valid === 1'b1) got_wb = wb;
            if (branch.load === 1'b1) got_br = branch;
            if (mem_req === 1'b1) got_cmd = mem_cmd;
        end while (done !== 1'b1 && lat < 40);
        chk("done", done, 1'b1);
    endtask
    task brc(logic [10:0] pc, logic tk, logic [10:0] tg);
        go(pc);
        if (lat_br < 0) lat_br = lat;
        chk("taken", got_br.load, tk);
        chk("target", got_br.target, tk ? tg : 11'h000);
        chk("branch time", lat, lat_br);
    endtask

    task t_branch;
        @(posedge clk);
        alu_flags_valid <= 1'b1;
        alu_zero <= 1'b1;
        @(posedge clk);
        alu_flags_valid <= 1'b0;
        alu_zero <= 1'b0;
        alu_ovf <= 1'b1;
        mk(branch_abs_op, cond_always, 16'h0000, 8'h00);
        i.use_reg_target = 1'b1;
        i.base_sel = 2'h2;
        brc(11'h050, 1'b1, 11'h010);
        mk(branch_abs_op, cond_zero, 16'h0000, 8'h00);
        i.imm_addr = 13'h0120;
        brc(11'h050, 1'b1, 11'h048);
        i.cond = cond_carry_out;
        brc(11'h050, 1'b0, 11'h000);
        chk("flags kept", {zero_flag, ovf_flag}, 2'h2);
        chk("branch span", lat_br == 4 || lat_br == 5, 1'b1);
        mk(branch_rel_on_accum, cond_min_met, 16'h0014, 8'h10);
        brc(11'h100, 1'b1, 11'h104);
        i.cond = cond_below;
        brc(11'h100, 1'b0, 11'h000);
        i.threshold = 16'h0015;
        i.step = 8'hF8;
        brc(11'h100, 1'b1, 11'h0FE);
    endtask
    task t_counter;
        mk(counter_add_op, cond_always, 16'h0000, 8'h05);
        go(11'h010);
        chk("add", loop_count, 8'h05);
        mk(counter_sub, cond_always, 16'h0000, 8'h07);
        go(11'h011);
        chk("sub wrap", loop_count, 8'hFE);
        chk("count time", lat, lat_br + 2);
        mk(counter_clear_op, cond_always, 16'h0000, 8'h00);
        go(11'h012);
        chk("clear", loop_count, 8'h00);
        mk(counter_add_op, cond_always, 16'h0000, 8'h03);
        go(11'h013);
        mk(branch_rel_on_counter, cond_below, 16'h0004, 8'h08);
        brc(11'h200, 1'b1, 11'h202);
        i.threshold = 16'h0003;
        brc(11'h200, 1'b0, 11'h000);
        i.cond = cond_below_or_same;
        brc(11'h200, 1'b1, 11'h202);
        i.cond = cond_min_met;
        brc(11'h200, 1'b1, 11'h202);
        i.threshold = 16'h0004;
        brc(11'h200, 1'b0, 11'h000);
        chk("count kept", loop_count, 8'h03);
    endtask
    task t_mem;
        @(posedge clk);
        stall <= 4'h5;
        mk(mem_write_op, cond_always, 16'h0000, 8'h00);
        i.val_sel = 2'h1;
        i.base_sel = 2'h2;
        i.offset = 10'h3F8;
        go(11'h123);
        lat_st = lat;
        chk("store addr", got_cmd.addr, 11'h00E);
        chk("store word", got_cmd.wdata, {11'h123, 5'h00, 16'hA5C3});
        chk("store we", got_cmd.we, 1'b1);
        @(posedge clk);
        stall <= 4'h0;
        i.op = mem_read_op;
        i.val_sel = 2'h3;
        i.base_sel = 2'h3;
        i.offset = 10'h004;
        go(11'h124);
        chk("load data", got_wb.data, 16'hA5C3);
        chk("load reg", got_wb.sel, 2'h3);
        chk("mem time", lat, lat_br + 4);
        chk("stall time", lat_st, lat + 2);
        chk("count kept", loop_count, 8'h03);
    endtask

    initial begin
        rst = 1'b1;
        issue_valid = 1'b0;
        issue_instr = '0;
        issue_pc = '0;
        alu_flags_valid = 1'b0;
        alu_zero = 1'b0;
        alu_ovf = 1'b0;
        stall = 4'h0;
        gpr = {16'h000D, 16'h0010, 16'hA5C3, 16'h0014};
        err_total = 0;
        n_compared = 0;
        lat_br = -1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("ready", issue_ready, 1'b1);
        chk("idle", {mem_req, wb.valid, branch.load, done}, 4'h0);
        chk("count", loop_count, 8'h00);
        chk("flags", {zero_flag, ovf_flag}, 2'h0);
        t_branch;
        t_counter;
        t_mem;
        results;
    end
endmodule // coproc_mem_branch_stage_unit_tb
